// [adc_ctrl_pkg.sv]
// adc_ctrl_pkg: shared constants and types for the converter control block.
// assumes a single 10 MHz clock and an 8-bit register port with a one-cycle
// read latency.
package adc_ctrl_pkg;

  // register map (byte addresses on the 8-bit register port)
  localparam logic [7:0] ADC_CONTROL_ADDR = 8'hc0;
  localparam logic [7:0] IRQ_STATUS_ADDR  = 8'hc1;
  localparam logic [7:0] IRQ_MASK_ADDR    = 8'hc2;

  // adc_control field positions
  localparam int POWER_ENABLE_BIT = 7;
  localparam int DONE_FLAG_BIT    = 4;
  localparam int ACTIVE_FLAG_BIT  = 3;
  localparam int RC_SELECT_BIT    = 2;
  localparam int CHANNEL_HI_BIT   = 1;
  localparam int CHANNEL_LO_BIT   = 0;

  // reset values
  localparam logic [7:0] ADC_CONTROL_RESET = 8'h02;
  localparam logic [7:0] IRQ_MASK_RESET    = 8'h00;
  // bits 6 and 5 are undefined and are driven as zero
  localparam logic [7:0] CONTROL_FIXED_ONE = 8'h00;

  // irq status bit positions
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_BITS        = 2;

  // timing counts
  localparam int MCYCLE_DIV_DEFAULT = 6;   // clocks per machine cycle
  localparam int CPU_CONV_MCYCLES   = 31;
  localparam int RC_SYNC_MIN_MCYCLES = 3;
  localparam int RC_SYNC_TICKS      = RC_SYNC_MIN_MCYCLES + 1;
  localparam int RC_CONV_CLOCKS     = 108;
  localparam int RC_CONV_CLOCKS_MAX = 112;
  localparam int COUNT_W            = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } bus_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_CONV_CPU,
    ST_CONV_RC,
    ST_FINISH
  } conv_state_t;

endpackage

// [mcycle_tick_gen.sv]
// mcycle_tick_gen: divides the system clock into one-cycle machine-cycle
// enable pulses. assumes the cpu clock tree stops in power-down, so the
// divider freezes there.
`timescale 1ns/1ps
`default_nettype none
module mcycle_tick_gen
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = MCYCLE_DIV_DEFAULT
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic halt_i,
  output logic      tick_o
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  initial begin
    if (DIV < 1) begin
      $error("mcycle_tick_gen: DIV must be at least 1");
    end
  end

  logic [W-1:0] div_q;

  // divider counter; holds while the cpu clock is stopped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
    end else if (!halt_i) begin
      if (div_q == W'(DIV - 1)) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + W'(1);
      end
    end
  end

  // registered tick so the pulse is glitch free downstream
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !halt_i && (div_q == W'(DIV - 1));
    end
  end

endmodule
`default_nettype wire

// [adc_sequencer.sv]
// adc_sequencer: control register, conversion sequencer and interrupt logic
// for a four-input converter. assumes the analog core samples the channel
// on analog_channel_o while conversion_active_o is high, and that rc_tick_i
// is a one-cycle pulse per rc oscillator period, synchronous to clk_i.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int MCYCLE_DIV = MCYCLE_DIV_DEFAULT
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire bus_req_t   bus_i,
  input  wire logic       rc_tick_i,
  input  wire logic       power_down_i,
  output logic [7:0]      rd_data_o,
  output logic [1:0]      analog_channel_o,
  output logic            converter_power_o,
  output logic            conversion_active_o,
  output logic            conversion_done_o,
  output logic            irq_o
);

  initial begin
    if (MCYCLE_DIV < 1) begin
      $error("adc_sequencer: MCYCLE_DIV must be at least 1");
    end
  end

  conv_state_t          state_q;
  logic [COUNT_W-1:0]   cnt_q;
  logic                 power_en_q;
  logic                 done_q;
  logic                 rc_sel_q;
  logic [1:0]           channel_q;
  logic [IRQ_BITS-1:0]  status_q;
  logic [IRQ_BITS-1:0]  mask_q;
  logic                 mcycle_tick;
  logic                 ctrl_wr;
  logic                 start_req;
  logic                 start_ok;
  logic                 finish_evt;
  logic                 busy;
  logic                 status_wr;

  // true when addr selects a given register
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // machine-cycle enables; cpu clock stops in power-down
  mcycle_tick_gen #(
    .DIV (MCYCLE_DIV)
  ) u_mcycle (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .halt_i    (power_down_i),
    .tick_o    (mcycle_tick)
  );

  // request decode
  assign busy      = (state_q != ST_IDLE);
  assign ctrl_wr   = bus_i.we && hit(bus_i.addr, ADC_CONTROL_ADDR);
  assign status_wr = bus_i.we && hit(bus_i.addr, IRQ_STATUS_ADDR);
  assign start_req = ctrl_wr && bus_i.wdata[ACTIVE_FLAG_BIT];
  // a start needs power on, no result pending and no conversion running;
  // the enable written in the same cycle counts
  assign start_ok  = start_req && bus_i.wdata[POWER_ENABLE_BIT]
                     && !done_q && !busy;

  // last count of the running phase reached
  assign finish_evt =
      (state_q == ST_CONV_CPU && mcycle_tick &&
       cnt_q == COUNT_W'(CPU_CONV_MCYCLES - 1)) ||
      (state_q == ST_CONV_RC && rc_tick_i &&
       cnt_q == COUNT_W'(RC_CONV_CLOCKS - 1));

  // control fields written by software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_en_q <= ADC_CONTROL_RESET[POWER_ENABLE_BIT];
      rc_sel_q   <= ADC_CONTROL_RESET[RC_SELECT_BIT];
      channel_q  <= ADC_CONTROL_RESET[CHANNEL_HI_BIT:CHANNEL_LO_BIT];
    end else if (ctrl_wr) begin
      power_en_q <= bus_i.wdata[POWER_ENABLE_BIT];
      rc_sel_q   <= bus_i.wdata[RC_SELECT_BIT];
      channel_q  <= bus_i.wdata[CHANNEL_HI_BIT:CHANNEL_LO_BIT];
    end
  end

  // completion flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_q <= ADC_CONTROL_RESET[DONE_FLAG_BIT];
    end else if (finish_evt && power_en_q) begin
      done_q <= 1'b1;
    end else if (ctrl_wr && !bus_i.wdata[DONE_FLAG_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else if (!power_en_q) begin
      // power off aborts any conversion and keeps busy low
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      if (start_ok) begin
        // enable and start written together
        state_q <= bus_i.wdata[RC_SELECT_BIT] ? ST_SYNC : ST_CONV_CPU;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            cnt_q <= '0;
            state_q <= bus_i.wdata[RC_SELECT_BIT] ? ST_SYNC : ST_CONV_CPU;
          end
        end
        ST_SYNC: begin
          // first tick lands anywhere in the current machine cycle, so the
          // sync costs between 3 and 4 full machine cycles
          if (mcycle_tick) begin
            if (cnt_q == COUNT_W'(RC_SYNC_TICKS - 1)) begin
              cnt_q   <= '0;
              state_q <= ST_CONV_RC;
            end else begin
              cnt_q <= cnt_q + COUNT_W'(1);
            end
          end
        end
        ST_CONV_CPU: begin
          // counts machine cycles; frozen in power-down as the cpu is
          if (mcycle_tick) begin
            cnt_q <= cnt_q + COUNT_W'(1);
          end
          if (finish_evt) begin
            state_q <= ST_FINISH;
          end
        end
        ST_CONV_RC: begin
          // rc ticks keep running in power-down, so this phase completes
          if (rc_tick_i) begin
            cnt_q <= cnt_q + COUNT_W'(1);
          end
          if (finish_evt) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          // done and busy both high until the next machine-cycle boundary
          if (mcycle_tick) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= '0;
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (status_wr && bus_i.wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      if (finish_evt && power_en_q) begin
        status_q[IRQ_DONE_BIT] <= 1'b1;
      end
      if (start_req && !start_ok) begin
        status_q[IRQ_REFUSED_BIT] <= 1'b1;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= IRQ_MASK_RESET[IRQ_BITS-1:0];
    end else if (bus_i.we && hit(bus_i.addr, IRQ_MASK_ADDR)) begin
      mask_q <= bus_i.wdata[IRQ_BITS-1:0];
    end
  end

  // read data one cycle after the strobe; undefined bits read as zero and
  // unmapped addresses return zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (bus_i.re) begin
      rd_data_o <= 8'h00;
      if (hit(bus_i.addr, ADC_CONTROL_ADDR)) begin
        rd_data_o <= CONTROL_FIXED_ONE | {power_en_q, 2'b00, done_q,
                     busy, rc_sel_q, channel_q};
      end else if (hit(bus_i.addr, IRQ_STATUS_ADDR)) begin
        rd_data_o <= {{(8-IRQ_BITS){1'b0}}, status_q};
      end else if (hit(bus_i.addr, IRQ_MASK_ADDR)) begin
        rd_data_o <= {{(8-IRQ_BITS){1'b0}}, mask_q};
      end
    end
  end

  // registered outputs toward the analog core and the cpu
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      analog_channel_o    <= ADC_CONTROL_RESET[CHANNEL_HI_BIT:CHANNEL_LO_BIT];
      converter_power_o   <= 1'b0;
      conversion_active_o <= 1'b0;
      conversion_done_o   <= 1'b0;
      irq_o               <= 1'b0;
    end else begin
      analog_channel_o    <= channel_q;
      converter_power_o   <= power_en_q;
      conversion_active_o <= busy;
      conversion_done_o   <= done_q;
      irq_o               <= |(status_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// [rc_osc_model.sv]
// rc_osc_model: the on-chip rc oscillator seen from the control block, one
// tick pulse per period. assumes a period of whole system clocks.
`timescale 1ns/1ps
`default_nettype none
module rc_osc_model #(
  parameter int PER = 4
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  output logic      rc_tick_o
);
  logic [7:0] cnt_q;
  // free running, power-down does not stop it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cnt_q == 8'(PER - 1)) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign rc_tick_o = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// [adc_sequencer_sva.sv]
// adc_sequencer_sva: port timing checks for the converter control block.
// assumes it is bound into adc_sequencer with the same MCYCLE_DIV.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_sva
  import adc_ctrl_pkg::*;
#(
  parameter int MCYCLE_DIV = MCYCLE_DIV_DEFAULT
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire bus_req_t   bus_i,
  input wire logic       rc_tick_i,
  input wire logic       power_down_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [1:0] analog_channel_o,
  input wire logic       converter_power_o,
  input wire logic       conversion_active_o,
  input wire logic       conversion_done_o,
  input wire logic       irq_o
);
  localparam int SPAN = MCYCLE_DIV;
  localparam int CPU_LO = 30 * MCYCLE_DIV;
  localparam int CPU_HI = 32 * MCYCLE_DIV + 2;
  localparam int RC_HI = RC_CONV_CLOCKS_MAX + 2;
  logic       rc_q;
  logic [9:0] act_q;
  logic [7:0] tck_q;
  wire logic       ctl_wr = bus_i.we && bus_i.addr == ADC_CONTROL_ADDR;
  wire logic       clr_w  = ctl_wr && !bus_i.wdata[DONE_FLAG_BIT];
  wire logic [1:0] ch_w   = bus_i.wdata[1:0];
  // clock mode is hidden at the ports, so track it from control writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) rc_q <= 1'b0;
    else if (ctl_wr) rc_q <= bus_i.wdata[RC_SELECT_BIT];
  end
  // busy length in clocks and in rc ticks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !conversion_active_o) begin
      act_q <= '0;
      tck_q <= '0;
    end else begin
      act_q <= act_q + 10'h001;
      // ticks after done rises belong to the hold state, not the conversion
      tck_q <= tck_q + {7'h00, rc_tick_i && !conversion_done_o};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_start_accept:
  assert property (ctl_wr && bus_i.wdata[7] && bus_i.wdata[3] &&
    converter_power_o && !conversion_active_o && !conversion_done_o
    |-> ##[1:3] conversion_active_o) else $error("start not taken");
  chk_power_gate:
  assert property (!converter_power_o [*3] |-> !conversion_active_o)
    else $error("busy while powered off");
  chk_done_busy:
  assert property ($rose(conversion_done_o) && !power_down_i |->
    conversion_active_o ##[1:SPAN] (!conversion_active_o && conversion_done_o))
    else $error("done state span wrong");
  chk_done_sticky:
  assert property ($fell(conversion_done_o) |-> $past(clr_w, 2))
    else $error("done cleared without write");
  chk_busy_hold:
  assert property ($fell(conversion_active_o) |->
    $past(conversion_done_o) || !$past(converter_power_o))
    else $error("busy dropped early");
  chk_cpu_time:
  assert property ($fell(conversion_active_o) && !rc_q && conversion_done_o
    |-> act_q >= CPU_LO && act_q <= CPU_HI) else $error("cpu time wrong");
  chk_rc_time:
  assert property ($fell(conversion_active_o) && rc_q && conversion_done_o
    |-> tck_q >= RC_CONV_CLOCKS && tck_q <= RC_HI) else $error("rc time");
  chk_channel_route:
  assert property (ctl_wr |-> ##2 analog_channel_o == $past(ch_w, 2))
    else $error("channel not routed");
  chk_fixed_zero:
  assert property (bus_i.re && bus_i.addr == ADC_CONTROL_ADDR |=>
    rd_data_o[6:5] == 2'b00) else $error("fixed bits not zero");
  cover property ($rose(conversion_done_o) && rc_q);
  cover property ($fell(conversion_active_o) && !conversion_done_o);
  cover property ($rose(irq_o));
endmodule
bind adc_sequencer adc_sequencer_sva #(.MCYCLE_DIV(MCYCLE_DIV)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
  .rc_tick_i(rc_tick_i), .power_down_i(power_down_i), .rd_data_o(rd_data_o),
  .analog_channel_o(analog_channel_o), .converter_power_o(converter_power_o),
  .conversion_active_o(conversion_active_o),
  .conversion_done_o(conversion_done_o), .irq_o(irq_o));
`default_nettype wire

// [tb_adc_sequencer.sv]
// tb_adc_sequencer: register-level tests of the converter control block.
// assumes an rc tick every 4 clocks and a machine cycle of 2 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_adc_sequencer
  import adc_ctrl_pkg::*;
();
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       power_down_i = 1'b0;
  bus_req_t   bus_q = '0;
  logic       rc_tick;
  logic [7:0] rd_data;
  logic [1:0] chan;
  logic       pwr;
  logic       act;
  logic       done;
  logic       irq;
  int         mismatches = 0;
  int         comparisons = 0;
  // 100 ns period keeps the cpu clock above 1 MHz
  initial forever #50 clk_i = ~clk_i;
  adc_sequencer #(.MCYCLE_DIV(2)) dut_u (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .bus_i(bus_q), .rc_tick_i(rc_tick),
    .power_down_i(power_down_i), .rd_data_o(rd_data),
    .analog_channel_o(chan), .converter_power_o(pwr),
    .conversion_active_o(act), .conversion_done_o(done), .irq_o(irq));
  rc_osc_model #(.PER(4)) rc_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rc_tick_o(rc_tick));
  // quiet cycle after each write so strobes never merge; bits 6:5 stay 0
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_q <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_q <= '0;
    @(posedge clk_i);
  endtask
  // read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus_q <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_q <= '0;
    #1 `CHK(rd_data, exp)
    @(posedge clk_i);
  endtask
  // bounded wait for completion, then let busy fall
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(done, 1'b1)
    repeat (4) @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is under 2000 cycles
  initial begin
    #(20000 * 100);
    mismatches++;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADC_CONTROL_ADDR, ADC_CONTROL_RESET);
    rd(IRQ_MASK_ADDR, IRQ_MASK_RESET);
    rd(IRQ_STATUS_ADDR, 8'h00);
    wr(ADC_CONTROL_ADDR, 8'h08);
    rd(ADC_CONTROL_ADDR, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADC_CONTROL_ADDR, 8'(c));
      #1 `CHK(chan, 2'(c))
      @(posedge clk_i);
    end
    wr(ADC_CONTROL_ADDR, 8'h81);
    #1 `CHK(pwr, 1'b1)
    @(posedge clk_i);
    wr(ADC_CONTROL_ADDR, 8'h8a);
    rd(ADC_CONTROL_ADDR, 8'h8a);
    // clear the refusal left by the powered-off start so this one counts
    wr(IRQ_STATUS_ADDR, 8'h02);
    wr(ADC_CONTROL_ADDR, 8'h89);
    rd(IRQ_STATUS_ADDR, 8'h02);
    wait_done(200);
    rd(ADC_CONTROL_ADDR, 8'h91);
    wr(ADC_CONTROL_ADDR, 8'h99);
    rd(ADC_CONTROL_ADDR, 8'h91);
    rd(IRQ_STATUS_ADDR, 8'h03);
    wr(IRQ_STATUS_ADDR, 8'h03);
    rd(IRQ_STATUS_ADDR, 8'h00);
    wr(ADC_CONTROL_ADDR, 8'h81);
    rd(ADC_CONTROL_ADDR, 8'h81);
    // rc conversion carried through a power-down spell
    wr(IRQ_MASK_ADDR, 8'h01);
    wr(ADC_CONTROL_ADDR, 8'h8c);
    repeat (40) @(posedge clk_i);
    power_down_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    #1 `CHK(act, 1'b1)
    // long enough for all 108 rc ticks while the cpu stays stopped
    repeat (321) @(posedge clk_i);
    #1 `CHK(done, 1'b1)
    @(posedge clk_i);
    power_down_i <= 1'b0;
    wait_done(800);
    rd(ADC_CONTROL_ADDR, 8'h94);
    `CHK(irq, 1'b1)
    wr(IRQ_MASK_ADDR, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h01);
    `CHK(irq, 1'b0)
    wr(IRQ_MASK_ADDR, 8'h01);
    rd(IRQ_STATUS_ADDR, 8'h01);
    `CHK(irq, 1'b1)
    wr(IRQ_STATUS_ADDR, 8'h01);
    rd(IRQ_STATUS_ADDR, 8'h00);
    `CHK(irq, 1'b0)
    // abort by dropping power in mid-conversion
    wr(ADC_CONTROL_ADDR, 8'h80);
    wr(ADC_CONTROL_ADDR, 8'h88);
    wr(ADC_CONTROL_ADDR, 8'h00);
    // wait past a full conversion so a missed abort would show
    repeat (80) @(posedge clk_i);
    rd(ADC_CONTROL_ADDR, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h00);
    #1 `CHK(pwr, 1'b0)
    end_sim;
  end
endmodule
`default_nettype wire
